/* File: rtl/pkt_cls_consts.vh */
/*
 * Constants for the packet classifier match block: field select codes,
 * which double as bit positions in the presence map, reported defaults,
 * protocol numbers and frame kinds.
 * Assumes inclusion by bare name from the classifier design files.
 */
`ifndef PKT_CLS_CONSTS_VH
`define PKT_CLS_CONSTS_VH

`define PC_NFIELDS     22
`define PC_FW          5
`define PC_DW          128
`define PC_F_PRIO      5'h00
`define PC_F_STATE     5'h01
`define PC_F_TOSLO     5'h02
`define PC_F_TOSHI     5'h03
`define PC_F_TOSMSK    5'h04
`define PC_F_PROTO     5'h05
`define PC_F_SRCIP     5'h06
`define PC_F_SRCMSK    5'h07
`define PC_F_DSTIP     5'h08
`define PC_F_DSTMSK    5'h09
`define PC_F_SPLO      5'h0A
`define PC_F_SPHI      5'h0B
`define PC_F_DPLO      5'h0C
`define PC_F_DPHI      5'h0D
`define PC_F_ICLO      5'h0E
`define PC_F_ICHI      5'h0F
`define PC_F_DMAC      5'h10
`define PC_F_DMMSK     5'h11
`define PC_F_SMAC      5'h12
`define PC_F_L3FMT     5'h13
`define PC_F_L3VAL     5'h14
`define PC_F_FAMILY    5'h15

`define PC_D_PRIO      8'h00
`define PC_D_STATE     1'h1
`define PC_D_TOS       8'h00
`define PC_PROTO_ANY   9'h100
`define PC_PROTO_TCPUDP 9'h101
`define PC_D_PROTO     9'h102
`define PC_D_SRCIP     36'h000000000
`define PC_D_SRCMSK    28'hFFFFFFF
`define PC_D_DSTIP     32'h00000000
`define PC_D_DSTMSK    32'hFFFFFFFF
`define PC_D_PORTLO    16'h0000
`define PC_D_PORTHI    16'hFFFF
`define PC_D_ICLO      8'h00
`define PC_D_ICHI      8'hFF
`define PC_D_DMAC      44'h00000000000
`define PC_D_DMMSK     48'h000000000000
`define PC_D_SMAC      40'hFFFFFFFFFF
`define PC_D_L3VAL     16'h0000

`define PC_FAM_IPV4    2'h1
`define PC_FAM_IPV6    2'h2
`define PC_V4_BITS     128'h000000000000000000000000FFFFFFFF

`define PC_L3_NONE     3'h0
`define PC_L3_ETYPE    3'h1
`define PC_L3_DSAP     3'h2
`define PC_L3_MAC      3'h3
`define PC_L3_ALL      3'h4

`define PC_K_DIX       2'h0
`define PC_K_SNAP      2'h1
`define PC_K_8023      2'h2
`define PC_K_MACMGT    2'h3

`define PC_IP_TCP      8'h06
`define PC_IP_UDP      8'h11
`define PC_IP_ICMP4    8'h01
`define PC_IP_ICMP6    8'h3A
`define PC_VLAN_TYPE   16'h8100
`define PC_SNAP_SAP    8'hAA

`endif

/* File: rtl/range_check.v */
/*
 * Inclusive range comparator used for every low/high criterion.
 * Purely combinational; the caller registers whatever depends on it.
 */
`timescale 1ns/1ps
module range_check #(
	parameter W = 8
) (
	input  wire [W-1:0] value,
	input  wire [W-1:0] low,
	input  wire [W-1:0] high,
	output wire         inRange
);
	// An inverted range (low above high) simply never matches.
	assign inRange = (value >= low) && (value <= high);
endmodule // range_check

/* File: rtl/packet_classifier_match.v */
/*
 * Packet classifier match block: a table of classifier entries written by
 * management software, a per-packet match of every entry, and a priority
 * pick of the winning entry. Also reports stored values and presence map.
 * Assumes packet header fields arrive already parsed, on this clock, with
 * pktValid high for one cycle per packet, and config from the same clock.
 */
// What this block does
// - Mask the packet ToS byte, then check it against the low/high range.
// - Unsignalled ToS high or mask reports zero.
// - Protocol must equal the configured value; 256 matches any protocol.
// - Configured protocol 257 matches both TCP and UDP.
// - Unsignalled protocol criterion reports 258.
// - Masked source IP must equal source value; family selects width.
// - Unsignalled source criteria report value 000000000 and mask FFFFFFF.
// - Masked destination IP must equal destination value; family selects width.
// - Unsignalled destination criteria report value 00000000, mask FFFFFFFF.
// - Source port inclusive range for TCP/UDP; ignored for other IP packets, fails non-IP; defaults 0/65535.
// - Destination port inclusive range; defaults report 0 and 65535.
// - ICMP type inclusive range; defaults report 0 and 255.
// - Masked destination MAC must equal value; defaults report zeros.
// - Source MAC must equal exactly; default reports FFFFFFFFFF.
// - Format none ignores layer-3 type; format all passes every frame.
// - Format ethertype only considers DIX or SNAP frames carrying a type.
// - Format dsap only considers 802.3 frames with DSAP other than 0xAA.
// - Format mac applies only to MAC management messages.
// - VLAN-tagged frames use the embedded type; format default reports 0.
// - Compare full type, low byte to DSAP, or bytes as message type bounds.
// - Higher priority entries win over lower ones.
// - Only entries whose activation state is enabled classify packets.
`timescale 1ns/1ps
`include "pkt_cls_consts.vh"
module packet_classifier_match #(
	parameter NUM_ENTRIES = 4,
	parameter IDX_W       = 2
) (
	input  wire                   clk,
	input  wire                   rst,
	input  wire                   cfgWrEn,
	input  wire                   cfgClr,
	input  wire [IDX_W-1:0]       cfgIndex,
	input  wire [`PC_FW-1:0]      cfgField,
	input  wire [`PC_DW-1:0]      cfgData,
	input  wire [IDX_W-1:0]       rdIndex,
	input  wire [`PC_FW-1:0]      rdField,
	input  wire                   pktValid,
	input  wire                   pktIsIp,
	input  wire                   pktIpv6,
	input  wire [7:0]             pktTos,
	input  wire [7:0]             pktProto,
	input  wire [127:0]           pktSrcIp,
	input  wire [127:0]           pktDstIp,
	input  wire [15:0]            pktSrcPort,
	input  wire [15:0]            pktDstPort,
	input  wire [7:0]             pktIcmpType,
	input  wire [47:0]            pktDstMac,
	input  wire [47:0]            pktSrcMac,
	input  wire [1:0]             pktFrameKind,
	input  wire [15:0]            pktOuterType,
	input  wire [15:0]            pktInnerType,
	input  wire [7:0]             pktDsap,
	input  wire [7:0]             pktMacMsgType,
	output reg  [`PC_DW-1:0]      rdData_ff,
	output reg  [`PC_NFIELDS-1:0] rdPresent_ff,
	output reg                    rdUsed_ff,
	output reg                    matchValid_ff,
	output reg                    matchHit_ff,
	output reg  [IDX_W-1:0]       matchIndex_ff,
	output reg  [7:0]             matchPrio_ff,
	output reg  [NUM_ENTRIES-1:0] hitVector_ff
);

	// Entry storage, one flip-flop array per field.
	reg [7:0]             prio    [0:NUM_ENTRIES-1];
	reg                   active  [0:NUM_ENTRIES-1];
	reg [7:0]             tosLo   [0:NUM_ENTRIES-1];
	reg [7:0]             tosHi   [0:NUM_ENTRIES-1];
	reg [7:0]             tosMsk  [0:NUM_ENTRIES-1];
	reg [8:0]             proto   [0:NUM_ENTRIES-1];
	reg [127:0]           srcIp   [0:NUM_ENTRIES-1];
	reg [127:0]           srcMsk  [0:NUM_ENTRIES-1];
	reg [127:0]           dstIp   [0:NUM_ENTRIES-1];
	reg [127:0]           dstMsk  [0:NUM_ENTRIES-1];
	reg [15:0]            spLo    [0:NUM_ENTRIES-1];
	reg [15:0]            spHi    [0:NUM_ENTRIES-1];
	reg [15:0]            dpLo    [0:NUM_ENTRIES-1];
	reg [15:0]            dpHi    [0:NUM_ENTRIES-1];
	reg [7:0]             icLo    [0:NUM_ENTRIES-1];
	reg [7:0]             icHi    [0:NUM_ENTRIES-1];
	reg [47:0]            dMac    [0:NUM_ENTRIES-1];
	reg [47:0]            dMacMsk [0:NUM_ENTRIES-1];
	reg [47:0]            sMac    [0:NUM_ENTRIES-1];
	reg [2:0]             l3Fmt   [0:NUM_ENTRIES-1];
	reg [15:0]            l3Val   [0:NUM_ENTRIES-1];
	reg [1:0]             family  [0:NUM_ENTRIES-1];
	reg [`PC_NFIELDS-1:0] present [0:NUM_ENTRIES-1];
	reg                   used    [0:NUM_ENTRIES-1];

	wire [NUM_ENTRIES-1:0] hit;
	wire                   pktTcpUdp;
	wire                   pktIcmp;
	wire [15:0]            effType;
	integer                e;

	assign pktTcpUdp = pktIsIp && (pktProto == `PC_IP_TCP || pktProto == `PC_IP_UDP);
	assign pktIcmp   = pktIsIp && (pktProto == `PC_IP_ICMP4 || pktProto == `PC_IP_ICMP6);
	// A tagged frame hides its real type behind the tag header.
	assign effType = (pktOuterType == `PC_VLAN_TYPE) ? pktInnerType : pktOuterType;

	// Clearing an entry reloads the reported defaults so that a read of an
	// unsignalled field shows the default value without extra muxing.
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			for (e = 0; e < NUM_ENTRIES; e = e + 1) begin
				prio[e]    <= `PC_D_PRIO;
				active[e]  <= `PC_D_STATE;
				tosLo[e]   <= `PC_D_TOS;
				tosHi[e]   <= `PC_D_TOS;
				tosMsk[e]  <= `PC_D_TOS;
				proto[e]   <= `PC_D_PROTO;
				srcIp[e]   <= {92'h0, `PC_D_SRCIP};
				srcMsk[e]  <= {100'h0, `PC_D_SRCMSK};
				dstIp[e]   <= {96'h0, `PC_D_DSTIP};
				dstMsk[e]  <= {96'h0, `PC_D_DSTMSK};
				spLo[e]    <= `PC_D_PORTLO;
				spHi[e]    <= `PC_D_PORTHI;
				dpLo[e]    <= `PC_D_PORTLO;
				dpHi[e]    <= `PC_D_PORTHI;
				icLo[e]    <= `PC_D_ICLO;
				icHi[e]    <= `PC_D_ICHI;
				dMac[e]    <= {4'h0, `PC_D_DMAC};
				dMacMsk[e] <= `PC_D_DMMSK;
				sMac[e]    <= {8'h00, `PC_D_SMAC};
				l3Fmt[e]   <= `PC_L3_NONE;
				l3Val[e]   <= `PC_D_L3VAL;
				family[e]  <= `PC_FAM_IPV4;
				present[e] <= 22'h000000;
				used[e]    <= 1'b0;
			end
		end else begin
			for (e = 0; e < NUM_ENTRIES; e = e + 1) begin
				if (cfgClr && cfgIndex == e[IDX_W-1:0]) begin
					prio[e]    <= `PC_D_PRIO;
					active[e]  <= `PC_D_STATE;
					tosLo[e]   <= `PC_D_TOS;
					tosHi[e]   <= `PC_D_TOS;
					tosMsk[e]  <= `PC_D_TOS;
					proto[e]   <= `PC_D_PROTO;
					srcIp[e]   <= {92'h0, `PC_D_SRCIP};
					srcMsk[e]  <= {100'h0, `PC_D_SRCMSK};
					dstIp[e]   <= {96'h0, `PC_D_DSTIP};
					dstMsk[e]  <= {96'h0, `PC_D_DSTMSK};
					spLo[e]    <= `PC_D_PORTLO;
					spHi[e]    <= `PC_D_PORTHI;
					dpLo[e]    <= `PC_D_PORTLO;
					dpHi[e]    <= `PC_D_PORTHI;
					icLo[e]    <= `PC_D_ICLO;
					icHi[e]    <= `PC_D_ICHI;
					dMac[e]    <= {4'h0, `PC_D_DMAC};
					dMacMsk[e] <= `PC_D_DMMSK;
					sMac[e]    <= {8'h00, `PC_D_SMAC};
					l3Fmt[e]   <= `PC_L3_NONE;
					l3Val[e]   <= `PC_D_L3VAL;
					family[e]  <= `PC_FAM_IPV4;
					present[e] <= 22'h000000;
					used[e]    <= 1'b0;
				end else if (cfgWrEn && cfgIndex == e[IDX_W-1:0]) begin
					used[e]    <= 1'b1;
					present[e] <= present[e] | (22'h000001 << cfgField);
					case (cfgField)
						`PC_F_PRIO:   prio[e]    <= cfgData[7:0];
						`PC_F_STATE:  active[e]  <= cfgData[0];
						`PC_F_TOSLO:  tosLo[e]   <= cfgData[7:0];
						`PC_F_TOSHI:  tosHi[e]   <= cfgData[7:0];
						`PC_F_TOSMSK: tosMsk[e]  <= cfgData[7:0];
						`PC_F_PROTO:  proto[e]   <= cfgData[8:0];
						`PC_F_SRCIP:  srcIp[e]   <= cfgData;
						`PC_F_SRCMSK: srcMsk[e]  <= cfgData;
						`PC_F_DSTIP:  dstIp[e]   <= cfgData;
						`PC_F_DSTMSK: dstMsk[e]  <= cfgData;
						`PC_F_SPLO:   spLo[e]    <= cfgData[15:0];
						`PC_F_SPHI:   spHi[e]    <= cfgData[15:0];
						`PC_F_DPLO:   dpLo[e]    <= cfgData[15:0];
						`PC_F_DPHI:   dpHi[e]    <= cfgData[15:0];
						`PC_F_ICLO:   icLo[e]    <= cfgData[7:0];
						`PC_F_ICHI:   icHi[e]    <= cfgData[7:0];
						`PC_F_DMAC:   dMac[e]    <= cfgData[47:0];
						`PC_F_DMMSK:  dMacMsk[e] <= cfgData[47:0];
						`PC_F_SMAC:   sMac[e]    <= cfgData[47:0];
						`PC_F_L3FMT:  l3Fmt[e]   <= cfgData[2:0];
						`PC_F_L3VAL:  l3Val[e]   <= cfgData[15:0];
						`PC_F_FAMILY: family[e]  <= cfgData[1:0];
						default:      used[e]    <= 1'b1;
					endcase
				end
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < NUM_ENTRIES; g = g + 1) begin : entry
			wire [`PC_NFIELDS-1:0] pr;
			wire                   tosIn;
			wire                   spIn;
			wire                   dpIn;
			wire                   icIn;
			wire                   msgIn;
			wire [127:0]           famBits;
			wire                   famOk;
			wire                   tosOk;
			wire                   protoOk;
			wire                   srcOk;
			wire                   dstOk;
			wire                   spOk;
			wire                   dpOk;
			wire                   icOk;
			wire                   dMacOk;
			wire                   sMacOk;
			reg                    l3Ok;

			assign pr = present[g];

			range_check #(.W(8)) u_tos (
				.value   (pktTos & tosMsk[g]),
				.low     (tosLo[g]),
				.high    (tosHi[g]),
				.inRange (tosIn)
			);
			range_check #(.W(16)) u_sp (
				.value   (pktSrcPort),
				.low     (spLo[g]),
				.high    (spHi[g]),
				.inRange (spIn)
			);
			range_check #(.W(16)) u_dp (
				.value   (pktDstPort),
				.low     (dpLo[g]),
				.high    (dpHi[g]),
				.inRange (dpIn)
			);
			range_check #(.W(8)) u_ic (
				.value   (pktIcmpType),
				.low     (icLo[g]),
				.high    (icHi[g]),
				.inRange (icIn)
			);
			range_check #(.W(8)) u_msg (
				.value   (pktMacMsgType),
				.low     (l3Val[g][7:0]),
				.high    (l3Val[g][15:8]),
				.inRange (msgIn)
			);

			assign tosOk = !(pr[`PC_F_TOSLO] || pr[`PC_F_TOSHI] || pr[`PC_F_TOSMSK])
				|| (pktIsIp && tosIn);
			assign protoOk = (proto[g] == `PC_PROTO_ANY) || (proto[g] == `PC_D_PROTO)
				|| (pktIsIp && ((proto[g] == `PC_PROTO_TCPUDP) ? pktTcpUdp
				: (proto[g] == {1'b0, pktProto})));
			// The family picks how many address bits take part.
			assign famBits = (family[g] == `PC_FAM_IPV6) ? {128{1'b1}} : `PC_V4_BITS;
			assign famOk = (family[g] == `PC_FAM_IPV6) == pktIpv6;
			assign srcOk = !(pr[`PC_F_SRCIP] || pr[`PC_F_SRCMSK]) || (pktIsIp && famOk
				&& (((pktSrcIp & srcMsk[g]) & famBits) == (srcIp[g] & famBits)));
			assign dstOk = !(pr[`PC_F_DSTIP] || pr[`PC_F_DSTMSK]) || (pktIsIp && famOk
				&& (((pktDstIp & dstMsk[g]) & famBits) == (dstIp[g] & famBits)));
			assign spOk = !(pr[`PC_F_SPLO] || pr[`PC_F_SPHI])
				|| (pktIsIp && (!pktTcpUdp || spIn));
			assign dpOk = !(pr[`PC_F_DPLO] || pr[`PC_F_DPHI])
				|| (pktIsIp && (!pktTcpUdp || dpIn));
			assign icOk = !(pr[`PC_F_ICLO] || pr[`PC_F_ICHI])
				|| (pktIsIp && (!pktIcmp || icIn));
			// Defaults give a zero mask and zero value, so absent always matches.
			assign dMacOk = (pktDstMac & dMacMsk[g]) == dMac[g];
			assign sMacOk = !pr[`PC_F_SMAC] || (pktSrcMac == sMac[g]);

			always @* begin
				case (l3Fmt[g])
					`PC_L3_NONE: l3Ok = 1'b1;
					`PC_L3_ALL:  l3Ok = 1'b1;
					`PC_L3_ETYPE: l3Ok = (pktFrameKind == `PC_K_DIX
						|| pktFrameKind == `PC_K_SNAP) && effType == l3Val[g];
					`PC_L3_DSAP: l3Ok = pktFrameKind == `PC_K_8023
						&& pktDsap != `PC_SNAP_SAP && pktDsap == l3Val[g][7:0];
					`PC_L3_MAC: l3Ok = pktFrameKind == `PC_K_MACMGT && msgIn;
					default:     l3Ok = 1'b0;
				endcase
			end

			assign hit[g] = used[g] && active[g]
				&& tosOk && protoOk && srcOk && dstOk && spOk && dpOk
				&& icOk && dMacOk && sMacOk && l3Ok;
		end
	endgenerate

	reg [IDX_W-1:0] nxt_matchIndex;
	reg [7:0]       nxt_matchPrio;
	reg             nxt_matchHit;
	integer         k;

	// Strictly greater keeps the lowest index on a priority tie.
	always @* begin
		nxt_matchIndex = {IDX_W{1'b0}};
		nxt_matchPrio  = 8'h00;
		nxt_matchHit   = 1'b0;
		for (k = 0; k < NUM_ENTRIES; k = k + 1) begin
			if (hit[k] && (!nxt_matchHit || prio[k] > nxt_matchPrio)) begin
				nxt_matchHit   = 1'b1;
				nxt_matchIndex = k[IDX_W-1:0];
				nxt_matchPrio  = prio[k];
			end
		end
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			matchValid_ff <= 1'b0;
			matchHit_ff   <= 1'b0;
			matchIndex_ff <= {IDX_W{1'b0}};
			matchPrio_ff  <= 8'h00;
			hitVector_ff  <= {NUM_ENTRIES{1'b0}};
		end else begin
			matchValid_ff <= pktValid;
			matchHit_ff   <= pktValid && nxt_matchHit;
			matchIndex_ff <= pktValid ? nxt_matchIndex : matchIndex_ff;
			matchPrio_ff  <= pktValid ? nxt_matchPrio : matchPrio_ff;
			hitVector_ff  <= pktValid ? hit : {NUM_ENTRIES{1'b0}};
		end
	end

	reg [`PC_DW-1:0] nxt_rdData;

	always @* begin
		case (rdField)
			`PC_F_PRIO:   nxt_rdData = {120'h0, prio[rdIndex]};
			`PC_F_STATE:  nxt_rdData = {127'h0, active[rdIndex]};
			`PC_F_TOSLO:  nxt_rdData = {120'h0, tosLo[rdIndex]};
			`PC_F_TOSHI:  nxt_rdData = {120'h0, tosHi[rdIndex]};
			`PC_F_TOSMSK: nxt_rdData = {120'h0, tosMsk[rdIndex]};
			`PC_F_PROTO:  nxt_rdData = {119'h0, proto[rdIndex]};
			`PC_F_SRCIP:  nxt_rdData = srcIp[rdIndex];
			`PC_F_SRCMSK: nxt_rdData = srcMsk[rdIndex];
			`PC_F_DSTIP:  nxt_rdData = dstIp[rdIndex];
			`PC_F_DSTMSK: nxt_rdData = dstMsk[rdIndex];
			`PC_F_SPLO:   nxt_rdData = {112'h0, spLo[rdIndex]};
			`PC_F_SPHI:   nxt_rdData = {112'h0, spHi[rdIndex]};
			`PC_F_DPLO:   nxt_rdData = {112'h0, dpLo[rdIndex]};
			`PC_F_DPHI:   nxt_rdData = {112'h0, dpHi[rdIndex]};
			`PC_F_ICLO:   nxt_rdData = {120'h0, icLo[rdIndex]};
			`PC_F_ICHI:   nxt_rdData = {120'h0, icHi[rdIndex]};
			`PC_F_DMAC:   nxt_rdData = {80'h0, dMac[rdIndex]};
			`PC_F_DMMSK:  nxt_rdData = {80'h0, dMacMsk[rdIndex]};
			`PC_F_SMAC:   nxt_rdData = {80'h0, sMac[rdIndex]};
			`PC_F_L3FMT:  nxt_rdData = {125'h0, l3Fmt[rdIndex]};
			`PC_F_L3VAL:  nxt_rdData = {112'h0, l3Val[rdIndex]};
			`PC_F_FAMILY: nxt_rdData = {126'h0, family[rdIndex]};
			default:      nxt_rdData = {`PC_DW{1'b0}};
		endcase
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			rdData_ff    <= {`PC_DW{1'b0}};
			rdPresent_ff <= {`PC_NFIELDS{1'b0}};
			rdUsed_ff    <= 1'b0;
		end else begin
			rdData_ff    <= nxt_rdData;
			rdPresent_ff <= present[rdIndex];
			rdUsed_ff    <= used[rdIndex];
		end
	end

endmodule // packet_classifier_match

/* File: sim/packet_classifier_match_checker.sv */
/* Concurrent checks on match timing, result coherence and table reads.
   Assumes binding onto packet_classifier_match; sees only its ports. */
`timescale 1ns/1ps
`include "pkt_cls_consts.vh"
module packet_classifier_match_checker #(
	parameter NUM_ENTRIES = 4,
	parameter IDX_W       = 2
) (
	input wire                   clk,
	input wire                   rst,
	input wire                   cfgWrEn,
	input wire                   cfgClr,
	input wire [IDX_W-1:0]       cfgIndex,
	input wire [`PC_FW-1:0]      cfgField,
	input wire [`PC_DW-1:0]      cfgData,
	input wire [IDX_W-1:0]       rdIndex,
	input wire [`PC_FW-1:0]      rdField,
	input wire                   pktValid,
	input wire [`PC_DW-1:0]      rdData_ff,
	input wire [`PC_NFIELDS-1:0] rdPresent_ff,
	input wire                   rdUsed_ff,
	input wire                   matchValid_ff,
	input wire                   matchHit_ff,
	input wire [IDX_W-1:0]       matchIndex_ff,
	input wire [NUM_ENTRIES-1:0] hitVector_ff
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence valueWrite;
		cfgWrEn && !cfgClr && cfgField == 5'h14 && rdField == 5'h14 && rdIndex == cfgIndex;
	endsequence
	sequence selHeld;
		$stable(rdIndex) && $stable(rdField);
	endsequence
	sequence protoClear;
		cfgClr && rdField == 5'h05 && rdIndex == cfgIndex;
	endsequence
	matchLatency_a: assert property (pktValid |=> matchValid_ff)
		else $error("no match result one cycle after a packet");
	noSpurious_a: assert property (!pktValid |=> !matchValid_ff && hitVector_ff == 0)
		else $error("match result without a packet");
	hitAgree_a: assert property (matchValid_ff |-> matchHit_ff == (|hitVector_ff))
		else $error("hit flag disagrees with hit vector");
	hitNeedsValid_a: assert property (matchHit_ff |-> matchValid_ff)
		else $error("hit flag outside a result cycle");
	winnerBit_a: assert property (matchHit_ff |-> hitVector_ff[matchIndex_ff])
		else $error("winning entry did not hit");
	indexHold_a: assert property (!pktValid |=> $stable(matchIndex_ff))
		else $error("winner index moved without a packet");
	writeSeen_a: assert property (valueWrite ##1 selHeld |=>
		rdData_ff == ($past(cfgData, 2) & 128'hFFFF) && rdPresent_ff[20] && rdUsed_ff)
		else $error("written value not read back");
	clearDefault_a: assert property (protoClear ##1 selHeld |=>
		rdData_ff == 128'h102 && rdPresent_ff == 0 && !rdUsed_ff)
		else $error("cleared entry does not report defaults");
endmodule // packet_classifier_match_checker

bind packet_classifier_match packet_classifier_match_checker #(
	.NUM_ENTRIES(NUM_ENTRIES),
	.IDX_W(IDX_W)
) chk_u (.*);

/* File: sim/pkt_source_model.sv */
/* Forwarding datapath model handing parsed header fields to the classifier.
   Assumes the bench calls load, may adjust fields, then calls fire. */
`timescale 1ns/1ps
module pkt_source_model (
	input  wire          clk,
	output logic         pktValid,
	output logic         pktIsIp,
	output logic         pktIpv6,
	output logic [7:0]   pktTos,
	output logic [7:0]   pktProto,
	output logic [127:0] pktSrcIp,
	output logic [127:0] pktDstIp,
	output logic [15:0]  pktSrcPort,
	output logic [15:0]  pktDstPort,
	output logic [7:0]   pktIcmpType,
	output logic [47:0]  pktDstMac,
	output logic [47:0]  pktSrcMac,
	output logic [1:0]   pktFrameKind,
	output logic [15:0]  pktOuterType,
	output logic [15:0]  pktInnerType,
	output logic [7:0]   pktDsap,
	output logic [7:0]   pktMacMsgType
);
	// The ICMP type follows the ToS byte so one loader serves every test.
	task automatic load(input logic [7:0] pr, ts, input logic [15:0] sp, dp);
		{pktIsIp, pktIpv6, pktProto, pktTos, pktIcmpType} = {2'h2, pr, ts, ts};
		{pktSrcIp, pktDstIp} = {128'h0A000001, 128'hC0A80101};
		{pktSrcPort, pktDstPort} = {sp, dp};
		{pktDstMac, pktSrcMac} = {48'h01005E000001, 48'h0012345678AB};
		{pktFrameKind, pktOuterType, pktInnerType} = {2'h0, 16'h0800, 16'h0};
		{pktDsap, pktMacMsgType} = 16'h0;
	endtask
	task automatic fire;
		@(posedge clk);
		#1 pktValid = 1'h1;
		@(posedge clk);
		#1 pktValid = 1'h0;
		// Fields are valid only at the sampling edge; flipping them exposes late capture.
		{pktIsIp, pktIpv6, pktTos, pktProto} = ~{pktIsIp, pktIpv6, pktTos, pktProto};
		{pktSrcIp, pktDstIp, pktSrcPort} = ~{pktSrcIp, pktDstIp, pktSrcPort};
		{pktDstPort, pktIcmpType, pktDstMac} = ~{pktDstPort, pktIcmpType, pktDstMac};
		{pktSrcMac, pktFrameKind, pktOuterType} = ~{pktSrcMac, pktFrameKind, pktOuterType};
		{pktInnerType, pktDsap, pktMacMsgType} = ~{pktInnerType, pktDsap, pktMacMsgType};
	endtask
	initial begin
		pktValid = 1'h0;
		load(8'h06, 8'h00, 16'h0000, 16'h0000);
	end
endmodule // pkt_source_model

/* File: sim/tb_packet_classifier_match.sv */
/* Self-checking bench for the classifier match block.
   Assumes the datapath model pkt_source_model and the bound checker. */
`timescale 1ns/1ps
module tb_packet_classifier_match;
	logic         clk = 1'h0, rst = 1'h1, cfgWrEn = 1'h0, cfgClr = 1'h0;
	logic [1:0]   cfgIndex = 2'h0, rdIndex = 2'h0, matchIndex_ff, pktFrameKind;
	logic [4:0]   cfgField = 5'h00, rdField = 5'h00;
	logic [127:0] cfgData = 128'h0, rdData_ff, pktSrcIp, pktDstIp;
	logic         pktValid, pktIsIp, pktIpv6, rdUsed_ff, matchValid_ff, matchHit_ff;
	logic [7:0]   pktTos, pktProto, pktIcmpType, pktDsap, pktMacMsgType, matchPrio_ff;
	logic [15:0]  pktSrcPort, pktDstPort, pktOuterType, pktInnerType;
	logic [47:0]  pktDstMac, pktSrcMac;
	logic [3:0]   hitVector_ff;
	logic [21:0]  rdPresent_ff;
	int           errors = 0, compares = 0;
	always #2.5 clk = ~clk;
	packet_classifier_match dut_u (.*);
	pkt_source_model pm_u (.*);
	task automatic check(input string what, input logic [127:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic tally_and_finish;
		if (errors == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic cfg(input logic clr, input logic [1:0] idx, input logic [4:0] f,
		input logic [127:0] d);
		@(posedge clk);
		#1 {cfgClr, cfgWrEn, cfgIndex, cfgField, cfgData} = {clr, !clr, idx, f, d};
		@(posedge clk);
		#1 {cfgClr, cfgWrEn} = 2'h0;
	endtask
	task automatic clrAll;
		for (int i = 0; i < 4; i++)
			cfg(1'h1, i[1:0], 5'h00, 128'h0);
	endtask
	task automatic rd(input logic [1:0] idx, input logic [4:0] f, input logic [127:0] exp);
		@(posedge clk);
		#1 {rdIndex, rdField} = {idx, f};
		@(posedge clk);
		#1 check("rdData", rdData_ff, exp);
	endtask
	task automatic shoot(input logic hit, input logic [1:0] idx);
		pm_u.fire();
		check("matchValid", matchValid_ff, 1'h1);
		check("matchHit", matchHit_ff, hit);
		if (hit)
			check("matchIndex", matchIndex_ff, idx);
	endtask
	task automatic pt(input logic [7:0] pr, ts, input logic [15:0] sp, dp, input logic hit,
		input logic [1:0] idx);
		pm_u.load(pr, ts, sp, dp);
		shoot(hit, idx);
	endtask
	task automatic tDefaults;
		{rdIndex, rdField} = {2'h0, 5'h05};
		clrAll();
		rd(2'h0, 5'h03, 128'h0);
		rd(2'h0, 5'h04, 128'h0);
		rd(2'h0, 5'h07, 128'hFFFFFFF);
		rd(2'h0, 5'h08, 128'h0);
		rd(2'h0, 5'h09, 128'hFFFFFFFF);
		rd(2'h0, 5'h0B, 128'hFFFF);
		rd(2'h0, 5'h0D, 128'hFFFF);
		rd(2'h0, 5'h0F, 128'hFF);
		rd(2'h0, 5'h11, 128'h0);
		rd(2'h0, 5'h12, 128'hFFFFFFFFFF);
		rd(2'h0, 5'h13, 128'h0);
	endtask
	task automatic tTos;
		clrAll();
		cfg(1'h0, 2'h0, 5'h02, 128'h10);
		cfg(1'h0, 2'h0, 5'h03, 128'h1F);
		cfg(1'h0, 2'h0, 5'h04, 128'hF0);
		pt(8'h06, 8'h1F, 16'h0050, 16'h0050, 1'h1, 2'h0);
		pt(8'h06, 8'h2A, 16'h0050, 16'h0050, 1'h0, 2'h0);
		pt(8'h06, 8'h0F, 16'h0050, 16'h0050, 1'h0, 2'h0);
	endtask
	task automatic tProto;
		logic [8:0] cp [3] = '{9'h006, 9'h100, 9'h101};
		logic [7:0] pr [3] = '{8'h06, 8'h11, 8'h01};
		logic       exp;
		for (int c = 0; c < 3; c++) begin
			clrAll();
			cfg(1'h0, 2'h1, 5'h05, {119'h0, cp[c]});
			for (int p = 0; p < 3; p++) begin
				exp = cp[c] == 9'h100 || (cp[c] == 9'h101 ? p < 2 : {1'h0, pr[p]} == cp[c]);
				pt(pr[p], 8'h00, 16'h0050, 16'h0050, exp, 2'h1);
			end
		end
	endtask
	task automatic tPorts;
		clrAll();
		cfg(1'h0, 2'h2, 5'h0A, 128'h64);
		cfg(1'h0, 2'h2, 5'h0B, 128'hC8);
		cfg(1'h0, 2'h2, 5'h0C, 128'h50);
		cfg(1'h0, 2'h2, 5'h0D, 128'h50);
		pt(8'h06, 8'h00, 16'h0064, 16'h0050, 1'h1, 2'h2);
		pt(8'h11, 8'h00, 16'h00C8, 16'h0050, 1'h1, 2'h2);
		pt(8'h06, 8'h00, 16'h00C9, 16'h0050, 1'h0, 2'h2);
		pt(8'h06, 8'h00, 16'h0064, 16'h0051, 1'h0, 2'h2);
		pt(8'h01, 8'h00, 16'h0001, 16'h0001, 1'h1, 2'h2);
	endtask
	task automatic tIcmp;
		clrAll();
		cfg(1'h0, 2'h3, 5'h0E, 128'h03);
		cfg(1'h0, 2'h3, 5'h0F, 128'h08);
		pt(8'h01, 8'h03, 16'h0050, 16'h0050, 1'h1, 2'h3);
		pt(8'h01, 8'h08, 16'h0050, 16'h0050, 1'h1, 2'h3);
		pt(8'h01, 8'h09, 16'h0050, 16'h0050, 1'h0, 2'h3);
		pt(8'h3A, 8'h02, 16'h0050, 16'h0050, 1'h0, 2'h3);
	endtask
	task automatic tAddrMac;
		logic [31:0] s [5] = '{32'h0A123456, 32'h0B123456, 32'h0AFFFFFF, 32'h0A000000,
			32'h0A000000};
		logic [31:0] d [5] = '{32'hC0A801FE, 32'hC0A801FE, 32'hC0A801FE, 32'hC0A80100,
			32'hC0A802FE};
		clrAll();
		cfg(1'h0, 2'h0, 5'h15, 128'h1);
		cfg(1'h0, 2'h0, 5'h06, 128'h0A000000);
		cfg(1'h0, 2'h0, 5'h07, 128'hFF000000);
		cfg(1'h0, 2'h0, 5'h08, 128'hC0A80100);
		cfg(1'h0, 2'h0, 5'h09, 128'hFFFFFF00);
		cfg(1'h0, 2'h0, 5'h10, 128'h010000000000);
		cfg(1'h0, 2'h0, 5'h11, 128'h010000000000);
		cfg(1'h0, 2'h0, 5'h12, 128'h0012345678AB);
		for (int i = 0; i < 5; i++) begin
			pm_u.load(8'h06, 8'h00, 16'h0050, 16'h0050);
			{pm_u.pktSrcIp, pm_u.pktDstIp} = {96'h0, s[i], 96'h0, d[i]};
			pm_u.pktDstMac[40] = i != 3;
			pm_u.pktSrcMac[0] = i != 2;
			shoot(i == 0, 2'h0);
		end
		cfg(1'h0, 2'h0, 5'h15, 128'h2);
		for (int i = 0; i < 2; i++) begin
			pm_u.load(8'h06, 8'h00, 16'h0050, 16'h0050);
			pm_u.pktIpv6 = i[0];
			shoot(i[0], 2'h0);
		end
	endtask
	task automatic tLayer3;
		logic [63:0] r [13] = '{64'h1080000800000001, 64'h1080010800000001,
			64'h1080008100080001, 64'h108000810086DD00, 64'h1080020800000000,
			64'h2004220000004201, 64'h200AA2000000AA00, 64'h2004200000004200,
			64'h3201030000002001, 64'h3201030000002100, 64'h3201000000001500,
			64'h4000020000000001, 64'h0000030000000001};
		clrAll();
		{rdIndex, rdField} = {2'h2, 5'h14};
		for (int i = 0; i < 13; i++) begin
			cfg(1'h0, 2'h2, 5'h13, {124'h0, r[i][63:60]});
			cfg(1'h0, 2'h2, 5'h14, {112'h0, r[i][59:44]});
			pm_u.load(8'h06, 8'h00, 16'h0050, 16'h0050);
			{pm_u.pktFrameKind, pm_u.pktOuterType, pm_u.pktInnerType} = r[i][41:8];
			{pm_u.pktDsap, pm_u.pktMacMsgType} = {2{r[i][15:8]}};
			shoot(r[i][0], 2'h2);
		end
	endtask
	task automatic tPrio;
		clrAll();
		cfg(1'h0, 2'h0, 5'h00, 128'h05);
		cfg(1'h0, 2'h3, 5'h00, 128'h09);
		pt(8'h11, 8'h00, 16'h0050, 16'h0050, 1'h1, 2'h3);
		check("matchPrio", matchPrio_ff, 128'h09);
		cfg(1'h0, 2'h3, 5'h01, 128'h0);
		pt(8'h11, 8'h00, 16'h0050, 16'h0050, 1'h1, 2'h0);
		cfg(1'h0, 2'h0, 5'h01, 128'h0);
		pt(8'h11, 8'h00, 16'h0050, 16'h0050, 1'h0, 2'h0);
	endtask
	initial begin
		repeat (8) @(posedge clk);
		#1 rst = 1'h0;
		tDefaults();
		tTos();
		tProto();
		tPorts();
		tIcmp();
		tAddrMac();
		tLayer3();
		tPrio();
		tally_and_finish();
	end
endmodule // tb_packet_classifier_match
